// File: hw/rafc_pkg.sv
// Package for the ringlet add flow control block: types and constants
package rafc_pkg;

    // Service classes as labelled on frames
    typedef enum logic [1:0] {
        CLASS_A = 2'h0,
        CLASS_B = 2'h1,
        CLASS_C = 2'h2,
        CLASS_R = 2'h3
    } rafc_class_t;

    // Class shapers an add frame can be charged to
    typedef enum logic [2:0] {
        SHP_NONE,
        SHP_SUB_A0,
        SHP_SUB_A1,
        SHP_COMMIT_B,
        SHP_FAIR_ELIGIBLE,
        SHP_CONTROL,
        SHP_IDLE
    } rafc_shaper_t;

    // Transit queue selection
    typedef enum logic [1:0] {
        TQ_NONE,
        TQ_PRIMARY,
        TQ_SECONDARY
    } rafc_tq_t;

    localparam int HOP_W = 8;
    localparam logic [HOP_W-1:0] MAX_STATIONS = 8'hFF;

    // Wishbone register map (byte addresses)
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_SEND   = 8'h08;
    localparam logic [ADDR_W-1:0] REG_COUNT  = 8'h0C;

    // Control register fields
    localparam int CTRL_DUAL_Q   = 0;
    localparam int CTRL_A1_SEL   = 1;
    localparam int CTRL_B_FORCE  = 2;
    localparam int CTRL_IDLE_EN  = 3;
    localparam int CTRL_CUT_THRU = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;

    // Stage queue sizing in bytes: one maximum-size frame for store and forward
    localparam int SIZE_MTU = 9216;
    localparam int STAGE_W  = 15;
    localparam logic [STAGE_W-1:0] STAGE_CAP = 15'h2400;

    // Fairness and shaper permissions sampled every cycle
    typedef struct packed {
        logic             subA0Permit;
        logic             subA1Permit;
        logic             commitBPermit;
        logic             fairEligiblePermit;
        logic             fairCongestedPermit;
        logic             downstreamPermit;
        logic             staticRateOk;
        logic             congestedRateOkFlag;
        logic [HOP_W-1:0] hopCountToChoke;
    } rafc_permit_t;

    // Send indications presented to the client
    typedef struct packed {
        logic             classASendOk;
        logic             classBCommitSendOk;
        logic [HOP_W-1:0] fairSendHopLimit;
    } rafc_send_t;

    // One add frame request from the client or control sublayer
    typedef struct packed {
        logic              valid;
        logic              fromControl;
        logic              idle;
        rafc_class_t       cls;
        logic [STAGE_W-1:0] length;
    } rafc_add_t;

endpackage

// File: hw/rafc_ring_add_flow_control.sv
// Per-ringlet datapath steering and add-traffic flow control
// Summary of operation
// - Single-queue mode puts every transit frame into the primary transit queue.
// - Dual-queue mode: class A to primary, classes B and C to secondary.
// - No preemption: a started transit or add frame runs to completion.
// - Device picks sub A0 or sub A1 shaper for class A client adds.
// - Device picks commit B or fair eligible shaper for class B adds.
// - Class C client adds are charged to the fair eligible shaper only.
// - Control frames use control shaper as class A, else class shapers.
// - Every unreserved add frame except idle frames is also charged to the downstream shaper.
// - Optional idle frames are charged to a dedicated idle shaper.
// - Accepted client frames enter a stage queue, possibly only logical.
// - Add traffic is rate controlled; transit traffic gets no rate control.
// - No shaping queues; client is throttled only through send indications.
// - Separate send indications: class A, class B commit, fair eligible.
// - Class A send is A0 permit, or A1 permit with downstream permit.
// - Class A send is zero when stage queue cannot accept a frame.
// - Indication conditions are evaluated in listed order, first match wins.
// - Store-and-forward stage holds one maximum frame; cut-through sends at once.
// - Class A and class B indications are binary.
// - Fair indication derives from fair, downstream and two rate checks.
// - Class B send is commit permit AND downstream permit when stage accepts.
// - All congested checks pass: fair indication equals maximum station count.
// - Else hop count when static checks pass; zero otherwise or stage full.
//
// The register addresses and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module rafc_ring_add_flow_control (
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           reset,
    // Classic Wishbone slave
    input  wire logic                           wbCyc,
    input  wire logic                           wbStb,
    input  wire logic                           wbWe,
    input  wire logic [rafc_pkg::ADDR_W-1:0]    wbAdr,
    input  wire logic [3:0]                     wbSel,
    input  wire logic [31:0]                    wbDatW,
    output logic      [31:0]                    wbDatR,
    output logic                                wbAck,
    // Shaper and fairness permissions
    input  wire rafc_pkg::rafc_permit_t         permit,
    // Send indications to the client
    output rafc_pkg::rafc_send_t                sendInd,
    // Client and control add frames
    input  wire rafc_pkg::rafc_add_t            addReq,
    output logic                                addReady,
    // Stage queue drain toward transmit selection
    input  wire logic                           stageDrain,
    input  wire logic [rafc_pkg::STAGE_W-1:0]   stageDrainLen,
    // Charge strobes toward shapers
    output logic                                shaperCharge,
    output rafc_pkg::rafc_shaper_t              shaperSel,
    output logic                                downstreamCharge,
    output logic      [rafc_pkg::STAGE_W-1:0]   chargeLen,
    // Transit frames
    input  wire logic                           transitValid,
    input  wire rafc_pkg::rafc_class_t          transitClass,
    input  wire logic                           transitLast,
    output rafc_pkg::rafc_tq_t                  transitQueue,
    // Transmit ownership of the link
    input  wire logic                           txStartTransit,
    input  wire logic                           txStartAdd,
    input  wire logic                           txFrameEnd,
    output logic                                txBusy
);

    typedef enum {FAIR_CHECK, FAIR_LONG, FAIR_SHORT, FAIR_DONE} rafc_fair_st_t;

    logic [4:0]                   ctrl_q;
    logic [rafc_pkg::STAGE_W-1:0] stageFill_q;
    logic [rafc_pkg::STAGE_W-1:0] stageFill_d;
    logic                         stageAccept;
    logic                         txBusy_q;
    logic                         transitOpen_q;
    rafc_pkg::rafc_send_t         send_d;
    rafc_pkg::rafc_send_t         send_q;
    rafc_pkg::rafc_shaper_t       shp_d;
    rafc_pkg::rafc_shaper_t       shp_q;
    rafc_pkg::rafc_tq_t           tq_d;
    rafc_pkg::rafc_tq_t           tq_q;
    logic                         charge_q;
    logic                         dsCharge_q;
    logic [rafc_pkg::STAGE_W-1:0] chargeLen_q;
    logic [15:0]                  addCount_q;
    logic                         ack_q;
    logic [31:0]                  datR_q;
    logic                         addTake;
    rafc_fair_st_t                fairSt;

    // Stage queue: byte counter only, frame data flows straight to transmit
    always_comb begin
        if (ctrl_q[rafc_pkg::CTRL_CUT_THRU]) begin
            stageAccept = (stageFill_q == '0) && !txBusy_q;
        end else begin
            stageAccept = stageFill_q <= (rafc_pkg::STAGE_CAP
                          - rafc_pkg::STAGE_W'(rafc_pkg::SIZE_MTU));
        end
    end

    assign addReady = stageAccept;
    assign addTake  = addReq.valid && stageAccept;

    always_comb begin
        stageFill_d = stageFill_q;
        if (addTake) begin
            stageFill_d = stageFill_d + addReq.length;
        end
        if (stageDrain) begin
            if (stageFill_d > stageDrainLen) begin
                stageFill_d = stageFill_d - stageDrainLen;
            end else begin
                stageFill_d = '0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            stageFill_q <= '0;
        end else begin
            stageFill_q <= stageFill_d;
        end
    end

    // Send indications, all from one table walk per cycle
    always_comb begin
        send_d = '0;
        fairSt = FAIR_CHECK;
        if (stageAccept) begin
            send_d.classASendOk = permit.subA0Permit
                || (permit.subA1Permit && permit.downstreamPermit);
            send_d.classBCommitSendOk = permit.commitBPermit
                && permit.downstreamPermit;
            fairSt = FAIR_LONG;
        end else begin
            send_d.classASendOk       = 1'b0;
            send_d.classBCommitSendOk = 1'b0;
            send_d.fairSendHopLimit   = '0;
        end
        case (fairSt)
            FAIR_LONG: begin
                if (permit.congestedRateOkFlag && permit.staticRateOk
                    && permit.fairCongestedPermit && permit.downstreamPermit) begin
                    send_d.fairSendHopLimit = rafc_pkg::MAX_STATIONS;
                end else if (permit.staticRateOk && permit.fairEligiblePermit
                    && permit.downstreamPermit) begin
                    send_d.fairSendHopLimit = permit.hopCountToChoke;
                end else begin
                    send_d.fairSendHopLimit = '0;
                end
            end
            FAIR_CHECK: begin
                send_d.fairSendHopLimit = '0;
            end
            default: begin
                send_d.fairSendHopLimit = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            send_q <= '0;
        end else begin
            send_q <= send_d;
        end
    end

    assign sendInd = send_q;

    // Shaper choice for the frame taken this cycle
    always_comb begin
        shp_d = rafc_pkg::SHP_NONE;
        if (addReq.idle) begin
            shp_d = ctrl_q[rafc_pkg::CTRL_IDLE_EN] ? rafc_pkg::SHP_IDLE
                                                    : rafc_pkg::SHP_NONE;
        end else begin
            case (addReq.cls)
                rafc_pkg::CLASS_A: begin
                    if (addReq.fromControl) begin
                        shp_d = rafc_pkg::SHP_CONTROL;
                    end else if (permit.subA0Permit && !ctrl_q[rafc_pkg::CTRL_A1_SEL]) begin
                        shp_d = rafc_pkg::SHP_SUB_A0;
                    end else begin
                        shp_d = rafc_pkg::SHP_SUB_A1;
                    end
                end
                rafc_pkg::CLASS_B: begin
                    if (send_q.classBCommitSendOk && !ctrl_q[rafc_pkg::CTRL_B_FORCE]) begin
                        shp_d = rafc_pkg::SHP_COMMIT_B;
                    end else begin
                        shp_d = rafc_pkg::SHP_FAIR_ELIGIBLE;
                    end
                end
                rafc_pkg::CLASS_C: begin
                    shp_d = rafc_pkg::SHP_FAIR_ELIGIBLE;
                end
                default: begin
                    shp_d = rafc_pkg::SHP_NONE;
                end
            endcase
        end
    end

    // Only add traffic is charged to shapers; transit passes uncharged
    always_ff @(posedge clk) begin
        if (reset) begin
            charge_q    <= 1'b0;
            dsCharge_q  <= 1'b0;
            shp_q       <= rafc_pkg::SHP_NONE;
            chargeLen_q <= '0;
        end else begin
            charge_q    <= addTake && (shp_d != rafc_pkg::SHP_NONE);
            dsCharge_q  <= addTake && !addReq.idle && (addReq.cls != rafc_pkg::CLASS_R);
            shp_q       <= addTake ? shp_d : rafc_pkg::SHP_NONE;
            chargeLen_q <= addTake ? addReq.length : '0;
        end
    end

    assign shaperCharge     = charge_q;
    assign downstreamCharge = dsCharge_q;
    assign shaperSel        = shp_q;
    assign chargeLen        = chargeLen_q;

    // Transit queue mapping, held for the whole frame
    always_comb begin
        if (ctrl_q[rafc_pkg::CTRL_DUAL_Q] && transitClass != rafc_pkg::CLASS_A) begin
            tq_d = rafc_pkg::TQ_SECONDARY;
        end else begin
            tq_d = rafc_pkg::TQ_PRIMARY;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tq_q          <= rafc_pkg::TQ_NONE;
            transitOpen_q <= 1'b0;
        end else if (transitValid) begin
            if (!transitOpen_q) begin
                tq_q <= tq_d;
            end
            transitOpen_q <= !transitLast;
        end else if (!transitOpen_q) begin
            tq_q <= rafc_pkg::TQ_NONE;
        end
    end

    assign transitQueue = tq_q;

    // Link ownership: a started frame blocks all other starts until its end
    always_ff @(posedge clk) begin
        if (reset) begin
            txBusy_q <= 1'b0;
        end else if (txBusy_q) begin
            txBusy_q <= !txFrameEnd;
        end else begin
            txBusy_q <= (txStartTransit || txStartAdd) && !txFrameEnd;
        end
    end

    assign txBusy = txBusy_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            addCount_q <= '0;
        end else if (addTake) begin
            addCount_q <= addCount_q + 16'h0001;
        end
    end

    // Wishbone slave: one wait state, ack drops after one cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wbCyc && wbStb && !ack_q;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_q <= rafc_pkg::CTRL_RESET;
        end else if (wbCyc && wbStb && wbWe && !ack_q && wbSel[0]
                     && wbAdr == rafc_pkg::REG_CTRL) begin
            ctrl_q <= wbDatW[4:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            datR_q <= 32'h0000_0000;
        end else if (wbCyc && wbStb && !ack_q) begin
            case (wbAdr)
                rafc_pkg::REG_CTRL:   datR_q <= {27'h0000000, ctrl_q};
                rafc_pkg::REG_STATUS: datR_q <= {13'h0000, stageAccept, txBusy_q,
                                                 transitOpen_q, 1'b0, stageFill_q};
                rafc_pkg::REG_SEND:   datR_q <= {22'h000000, send_q};
                rafc_pkg::REG_COUNT:  datR_q <= {16'h0000, addCount_q};
                default:              datR_q <= 32'h0000_0000;
            endcase
        end
    end

    assign wbAck  = ack_q;
    assign wbDatR = datR_q;

endmodule

`default_nettype wire

// File: bench/rafc_ring_add_flow_control_sva.sv
// Assertion checker for the ring add flow control block
`timescale 1ns/1ps
`default_nettype none
module rafc_ring_add_flow_control_sva (
    // Clock and reset
    input wire logic                   clk,
    input wire logic                   reset,
    // Permissions and indications
    input wire rafc_pkg::rafc_permit_t permit,
    input wire rafc_pkg::rafc_send_t   sendInd,
    // Add path
    input wire rafc_pkg::rafc_add_t    addReq,
    input wire logic                   addReady,
    input wire logic                   shaperCharge,
    input wire logic                   downstreamCharge,
    // Transit and transmit
    input wire logic                   transitValid,
    input wire logic                   transitLast,
    input wire rafc_pkg::rafc_tq_t     transitQueue,
    input wire logic                   txStartTransit,
    input wire logic                   txStartAdd,
    input wire logic                   txBusy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Tracks whether a transit frame is open, so back-to-back frames may re-steer
    logic frameOpen_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            frameOpen_q <= 1'b0;
        end else if (transitValid) begin
            frameOpen_q <= !transitLast;
        end
    end
    // Congested check is tried before the static one, first match wins
    function automatic logic [7:0] fairExp(input rafc_pkg::rafc_permit_t p, input logic rdy);
        return !rdy ? 8'h00
            : (p.congestedRateOkFlag && p.staticRateOk && p.fairCongestedPermit
               && p.downstreamPermit) ? rafc_pkg::MAX_STATIONS
            : (p.staticRateOk && p.fairEligiblePermit && p.downstreamPermit)
              ? p.hopCountToChoke : 8'h00;
    endfunction
    chk_class_a_send: assert property (
        !$past(reset) |-> sendInd.classASendOk == $past(addReady
            && (permit.subA0Permit || permit.subA1Permit && permit.downstreamPermit)))
        else $error("class A indication wrong");
    chk_class_b_send: assert property (
        !$past(reset) |-> sendInd.classBCommitSendOk
            == $past(addReady && permit.commitBPermit && permit.downstreamPermit))
        else $error("class B indication wrong");
    chk_fair_hop_limit: assert property (
        !$past(reset) |-> sendInd.fairSendHopLimit == $past(fairExp(permit, addReady)))
        else $error("fair hop limit wrong");
    chk_reset_clears: assert property (
        $fell(reset) |-> sendInd == '0) else $error("indications not cleared");
    chk_charge_cause: assert property (
        shaperCharge |-> !$past(reset) && $past(addReq.valid && addReady))
        else $error("charge without accepted frame");
    chk_downstream_charge: assert property (
        !$past(reset) && $past(addReq.valid && addReady && !addReq.idle
            && addReq.cls != rafc_pkg::CLASS_R) |-> downstreamCharge && shaperCharge)
        else $error("downstream shaper not charged");
    chk_transit_hold: assert property (
        $past(transitValid && frameOpen_q)
            |-> $stable(transitQueue)) else $error("transit queue changed in frame");
    chk_tx_busy_rise: assert property (
        !$past(reset) && $past(txStartTransit || txStartAdd) |-> txBusy)
        else $error("busy not raised after start");
endmodule
bind rafc_ring_add_flow_control rafc_ring_add_flow_control_sva u_sva (.*);
`default_nettype wire

// File: bench/rafc_client_model.sv
// Client model that offers client add frames only as the send indications allow
`timescale 1ns/1ps
`default_nettype none
module rafc_client_model (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset,
    // Frame wanted by the bench, hop distance of class C frames
    input  wire rafc_pkg::rafc_add_t  want,
    input  wire logic [7:0]           hops,
    // Indications from the block
    input  wire rafc_pkg::rafc_send_t sendInd,
    input  wire logic                 addReady,
    // Frame offered to the block
    output rafc_pkg::rafc_add_t       addReq
);
    logic fair;
    logic ok;
    assign fair = sendInd.fairSendHopLimit != 8'h00;
    // Control and idle frames come from the MAC itself, not throttled here
    assign ok = want.fromControl || want.idle
        || (want.cls == rafc_pkg::CLASS_A && sendInd.classASendOk)
        || (want.cls == rafc_pkg::CLASS_B && (sendInd.classBCommitSendOk || fair))
        || (want.cls == rafc_pkg::CLASS_C && fair && sendInd.fairSendHopLimit >= hops);
    // Released request shows inverted length so stale fields never look live
    always_ff @(posedge clk) begin
        if (reset) begin
            addReq <= '0;
        end else if (addReq.valid && addReady) begin
            addReq.valid  <= 1'b0;
            addReq.length <= ~addReq.length;
        end else if (!addReq.valid && want.valid && ok) begin
            addReq <= want;
        end
    end
endmodule
`default_nettype wire

// File: bench/rafc_ring_add_flow_control_bench.sv
// Self-checking bench for the ring add flow control block
`timescale 1ns/1ps
`default_nettype none
module rafc_ring_add_flow_control_bench;
    logic                   clk, reset, wbCyc, wbStb, wbWe, wbAck, addReady, stageDrain;
    logic                   shaperCharge, downstreamCharge, transitValid, transitLast;
    logic                   txStartTransit, txStartAdd, txFrameEnd, txBusy;
    logic [7:0]             wbAdr, hops;
    logic [31:0]            wbDatW, wbDatR, rd;
    logic [14:0]            stageDrainLen, chargeLen;
    rafc_pkg::rafc_permit_t permit;
    rafc_pkg::rafc_send_t   sendInd;
    rafc_pkg::rafc_add_t    addReq, want;
    rafc_pkg::rafc_shaper_t shaperSel;
    rafc_pkg::rafc_class_t  transitClass;
    rafc_pkg::rafc_tq_t     transitQueue;
    int                     nErrors, checkCount;
    rafc_ring_add_flow_control DUT (.wbSel(4'hF), .*);
    rafc_client_model client (.*);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            nErrors++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", checkCount, nErrors);
        if (nErrors == 0 && checkCount > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int i;
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= we;
        wbAdr  <= a;
        wbDatW <= d;
        for (i = 0; i < 20 && wbAck !== 1'b1; i++) @(posedge clk);
        if (i == 20) begin
            check(32'h0, 32'h1);
            wrap_up;
        end
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic t_reset;
        check({22'h0, sendInd}, 32'h0);
        wb(1'b0, rafc_pkg::REG_CTRL, 32'h0);
        check(rd, 32'h0);
        wb(1'b0, 8'h10, 32'h0);
        check(rd, 32'h0);
        wb(1'b0, rafc_pkg::REG_STATUS, 32'h0);
        check({31'h0, rd[18]}, 32'h1);
    endtask
    task automatic t_send;
        logic [7:0] f;
        for (int i = 0; i < 256; i++) begin
            permit <= {i[7:0], 8'h05};
            repeat (2) @(posedge clk);
            f = (i[0] && i[1] && i[3] && i[2]) ? rafc_pkg::MAX_STATIONS
                : (i[1] && i[4] && i[2]) ? 8'h05 : 8'h00;
            check({22'h0, sendInd}, {22'h0, i[7] | i[6] & i[2], i[5] & i[2], f});
        end
    endtask
    task automatic add(input rafc_pkg::rafc_class_t c, input logic ctl, input logic idl,
                       input rafc_pkg::rafc_shaper_t sel, input logic ds);
        int i;
        want <= '{1'b1, ctl, idl, c, 15'h0040};
        for (i = 0; i < 20 && shaperCharge !== 1'b1; i++) begin
            @(posedge clk);
            want.valid <= want.valid && !addReq.valid;
        end
        if (i == 20) begin
            check(32'h0, 32'h1);
            wrap_up;
        end
        check({29'h0, shaperSel}, {29'h0, sel});
        check({16'h0, downstreamCharge, chargeLen}, {16'h0, ds, 15'h0040});
        if (!idl) begin
            check({31'h0, addReady}, 32'h0);
            repeat (2) @(posedge clk);
            check({22'h0, sendInd}, 32'h0);
        end
        stageDrainLen <= 15'h0040;
        // Idle frames occupy the stage as well, so every frame is drained
        stageDrain <= 1'b1;
        @(posedge clk);
        stageDrain <= 1'b0;
        repeat (2) @(posedge clk);
        check({31'h0, addReady}, 32'h1);
    endtask
    task automatic t_transit;
        rafc_pkg::rafc_tq_t e;
        for (int d = 0; d < 2; d++) begin
            wb(1'b1, rafc_pkg::REG_CTRL, 32'(d));
            for (int c = 0; c < 3; c++) begin
                e = (d == 0 || c == 0) ? rafc_pkg::TQ_PRIMARY : rafc_pkg::TQ_SECONDARY;
                // Class changes mid-frame must not re-steer the frame
                for (int b = 0; b < 3; b++) begin
                    transitValid <= 1'b1;
                    transitClass <= rafc_pkg::rafc_class_t'(b == 0 ? c[1:0] : (c == 0 ? 2'h2 : 2'h0));
                    transitLast <= (b == 2);
                    @(posedge clk);
                    if (b > 0) check({30'h0, transitQueue}, {30'h0, e});
                end
                transitValid <= 1'b0;
                transitLast <= 1'b0;
                repeat (2) @(posedge clk);
                check({30'h0, transitQueue}, 32'h0);
            end
        end
    endtask
    task automatic t_tx;
        // Cut-through stage: accepts only while the link is free
        wb(1'b1, rafc_pkg::REG_CTRL, 32'h10);
        txStartTransit <= 1'b1;
        @(posedge clk);
        txStartTransit <= 1'b0;
        txStartAdd <= 1'b1;
        @(posedge clk);
        txStartAdd <= 1'b0;
        repeat (2) @(posedge clk);
        check({31'h0, txBusy}, 32'h1);
        check({31'h0, addReady}, 32'h0);
        txFrameEnd <= 1'b1;
        @(posedge clk);
        txFrameEnd <= 1'b0;
        repeat (2) @(posedge clk);
        check({31'h0, txBusy}, 32'h0);
        check({31'h0, addReady}, 32'h1);
    endtask
    initial begin
        {reset, wbCyc, wbStb, wbWe, stageDrain, transitValid, transitLast} = 7'h40;
        {txStartTransit, txStartAdd, txFrameEnd, wbAdr, wbDatW, stageDrainLen} = '0;
        {permit, want, nErrors, checkCount} = '0;
        transitClass = rafc_pkg::CLASS_A;
        hops = 8'h03;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset;
        t_send;
        permit <= 16'hFF05;
        repeat (2) @(posedge clk);
        add(rafc_pkg::CLASS_A, 1'b0, 1'b0, rafc_pkg::SHP_SUB_A0, 1'b1);
        wb(1'b1, rafc_pkg::REG_CTRL, 32'h2);
        add(rafc_pkg::CLASS_A, 1'b0, 1'b0, rafc_pkg::SHP_SUB_A1, 1'b1);
        add(rafc_pkg::CLASS_B, 1'b0, 1'b0, rafc_pkg::SHP_COMMIT_B, 1'b1);
        wb(1'b1, rafc_pkg::REG_CTRL, 32'hC);
        add(rafc_pkg::CLASS_B, 1'b0, 1'b0, rafc_pkg::SHP_FAIR_ELIGIBLE, 1'b1);
        add(rafc_pkg::CLASS_C, 1'b0, 1'b0, rafc_pkg::SHP_FAIR_ELIGIBLE, 1'b1);
        add(rafc_pkg::CLASS_A, 1'b1, 1'b0, rafc_pkg::SHP_CONTROL, 1'b1);
        add(rafc_pkg::CLASS_C, 1'b1, 1'b0, rafc_pkg::SHP_FAIR_ELIGIBLE, 1'b1);
        wb(1'b0, rafc_pkg::REG_COUNT, 32'h0);
        check(rd, 32'h7);
        add(rafc_pkg::CLASS_A, 1'b0, 1'b1, rafc_pkg::SHP_IDLE, 1'b0);
        t_transit;
        t_tx;
        wrap_up;
    end
endmodule
`default_nettype wire
